// ==== rtl/usbr_responder.sv ====
`timescale 1ns/1ps
module usbr_responder
   import usbr_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        tok_valid,
   input  usbr_pid_t        tok_pid,
   input  wire logic [1:0]  tok_ep,
   input  wire logic        tok_addr_ok,
   input  wire logic        rx_start,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_done,
   input  wire logic [4:0]  rx_count,
   input  wire logic        rx_ok,
   input  wire logic        rx_toggle,
   output logic             hs_valid,
   output usbr_hs_t         hs_code,
   output logic [3:0]       tx_len,
   output logic             tx_toggle,
   input  wire logic [2:0]  tx_index,
   output logic [7:0]       tx_byte,
   input  wire logic        host_hs_valid,
   input  wire logic        host_hs_ack,
   output logic [2:0]       ep_irq
);

   function automatic usbr_resp_t resp_of(input logic [3:0] m, input logic st, input usbr_pid_t p);
      usbr_resp_t s;
      usbr_resp_t i;
      usbr_resp_t o;
      s = RSP_IGNORE;
      i = RSP_IGNORE;
      o = RSP_IGNORE;
      case (m)
         MODE_NAK_INOUT:     begin s = RSP_ACK; i = RSP_NAK;   o = RSP_NAK;   end
         MODE_STATUS_OUT:    begin s = RSP_ACK; i = RSP_STALL; o = RSP_CHECK; end
         MODE_STALL_INOUT:   begin s = RSP_ACK; i = RSP_STALL; o = RSP_STALL; end
         MODE_IGNORE_INOUT:  s = RSP_ACK;
         MODE_STATUS_IN:     begin s = RSP_ACK; i = RSP_TX0;   o = RSP_STALL; end
         MODE_NAK_OUT:       o = RSP_NAK;
         MODE_ACK_OUT:       o = st ? RSP_STALL : RSP_ACK;
         MODE_NAKOUT_STATIN: begin s = RSP_ACK; i = RSP_TX0;   o = RSP_NAK;   end
         MODE_ACKOUT_NAKIN:  begin s = RSP_ACK; i = RSP_NAK;   o = RSP_ACK;   end
         MODE_NAK_IN:        i = RSP_NAK;
         MODE_ACK_IN:        i = st ? RSP_STALL : RSP_TXCNT;
         MODE_NAKIN_STATOUT: begin s = RSP_ACK; i = RSP_NAK;   o = RSP_CHECK; end
         MODE_ACKIN_STATOUT: begin s = RSP_ACK; i = RSP_TXCNT; o = RSP_CHECK; end
         default:            s = RSP_IGNORE;
      endcase
      case (p)
         PID_SETUP: resp_of = s;
         PID_IN:    resp_of = i;
         default:   resp_of = o;
      endcase
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[7:ATOP_LSB] == 2'h0) && (a[1:0] == 2'h0) && (a[AEP_LSB +: 2] < 2'(NUM_EP));
   endfunction

   // auto mode changes after an ACK
   function automatic logic [3:0] after_ack(input logic [3:0] m);
      case (m)
         MODE_ACK_OUT:       after_ack = MODE_NAK_OUT;
         MODE_ACKOUT_NAKIN:  after_ack = MODE_NAK_INOUT;
         MODE_ACK_IN:        after_ack = MODE_NAK_IN;
         MODE_ACKIN_STATOUT: after_ack = MODE_NAKIN_STATOUT;
         default:            after_ack = m;
      endcase
   endfunction

   logic [3:0]  mode  [NUM_EP];
   logic        stall [NUM_EP];
   logic        ack_f [NUM_EP];
   logic [3:0]  count [NUM_EP];
   logic        dval  [NUM_EP];
   logic        tog   [NUM_EP];
   logic [7:0]  bufm  [NUM_EP][EP_SIZE];
   logic        setup_f;
   logic        in_f;
   logic        out_f;
   logic        lock0;
   usbr_state_t state;
   usbr_state_t next_state;
   logic [1:0]  cur_ep;
   usbr_pid_t   cur_pid;
   usbr_resp_t  cur_resp;
   logic [3:0]  rx_idx;

   // Bus decode
   wire         wr_go   = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire         wr_ok   = addr_ok(s_axi_awaddr);
   wire  [1:0]  wr_ep   = s_axi_awaddr[AEP_LSB +: 2];
   wire  [1:0]  wr_reg  = s_axi_awaddr[AREG_LSB +: 2];
   wire         rd_go   = ce & s_axi_arvalid & ~s_axi_rvalid;
   wire         rd_ok   = addr_ok(s_axi_araddr);
   wire  [1:0]  rd_ep   = s_axi_araddr[AEP_LSB +: 2];
   wire  [1:0]  rd_reg  = s_axi_araddr[AREG_LSB +: 2];
   wire         unlock  = rd_go & rd_ok & (rd_ep == 2'h0) & ((rd_reg == REG_MODE) | (rd_reg == REG_COUNT));

   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   // Token decode
   wire         tok_ep_ok = tok_ep < 2'(NUM_EP);
   wire         tok_take  = ce & tok_valid & tok_addr_ok & tok_ep_ok & (state == ST_IDLE);
   wire  [3:0]  tok_mode  = tok_ep_ok ? mode[tok_ep] : MODE_DISABLE;
   // stall bit only on non-control endpoints
   wire         tok_stall = tok_ep_ok & (tok_ep != 2'h0) & stall[tok_ep];
   wire usbr_resp_t tok_resp = resp_of(tok_mode, tok_stall, tok_pid);
   wire  [3:0]  cur_mode  = mode[cur_ep];
   // count incl. CRC within size + 2, checks passed
   wire         pkt_good  = rx_ok & (rx_count <= PKT_MAX);
   wire         rx_we     = ce & (state == ST_DATA) & rx_valid & (cur_resp == RSP_ACK) & (rx_idx < 4'(EP_SIZE));

   logic        hs_fire;
   usbr_hs_t    hs_sel;
   logic        ack_set;
   logic        in_set;
   logic        out_set;
   logic        mode_we;
   logic [3:0]  mode_val;
   logic        cnt_we;
   logic        dval_val;
   logic        irq_fire;

   always_comb
   begin
      next_state = state;
      hs_fire    = 1'b0;
      hs_sel     = HS_NAK;
      ack_set    = 1'b0;
      in_set     = 1'b0;
      out_set    = 1'b0;
      mode_we    = 1'b0;
      mode_val   = after_ack(cur_mode);
      cnt_we     = 1'b0;
      dval_val   = pkt_good;
      irq_fire   = 1'b0;
      case (state)
         ST_IDLE:
            if (tok_take)
            begin
               if (tok_pid == PID_IN)
               begin
                  case (tok_resp)
                     RSP_NAK, RSP_STALL:
                     begin
                        hs_fire  = 1'b1;
                        // Flag and irq use tok_ep below; cur_ep is stale here
                        hs_sel   = (tok_resp == RSP_NAK) ? HS_NAK : HS_STALL;
                     end
                     // data packet of count or zero bytes
                     RSP_TXCNT, RSP_TX0:
                     begin
                        hs_fire    = 1'b1;
                        hs_sel     = HS_DATA;
                        next_state = ST_INACK;
                     end
                     default: next_state = ST_IDLE;
                  endcase
               end
               else if (tok_resp != RSP_IGNORE)
                  next_state = ST_DATA;
            end
         ST_DATA:
            if (ce & rx_done)
            begin
               next_state = ST_IDLE;
               case (cur_resp)
                  RSP_ACK:
                  begin
                     cnt_we   = 1'b1;
                     irq_fire = 1'b1;
                     out_set  = (cur_pid == PID_OUT);
                     if (pkt_good)
                     begin
                        hs_fire = 1'b1;
                        hs_sel  = HS_ACK;
                        ack_set = 1'b1;
                        mode_we = 1'b1;
                        // accepted SETUP goes to NAK mode
                        if (cur_pid == PID_SETUP)
                           mode_val = MODE_NAK_INOUT;
                     end
                  end
                  RSP_NAK, RSP_STALL:
                     if (pkt_good)
                     begin
                        hs_fire  = 1'b1;
                        hs_sel   = (cur_resp == RSP_NAK) ? HS_NAK : HS_STALL;
                        out_set  = 1'b1;
                        irq_fire = 1'b1;
                     end
                  // zero-length OUT with toggle 1 only
                  RSP_CHECK:
                     if (pkt_good)
                     begin
                        hs_fire  = 1'b1;
                        out_set  = 1'b1;
                        irq_fire = 1'b1;
                        cnt_we   = 1'b1;
                        dval_val = 1'b1;
                        if ((rx_count == ZLP_COUNT) & rx_toggle)
                        begin
                           hs_sel  = HS_ACK;
                           ack_set = 1'b1;
                           // 1111 to 1110 on status OUT
                           mode_we = 1'b1;
                        end
                        else
                           hs_sel = HS_STALL;
                     end
                  default: next_state = ST_IDLE;
               endcase
            end
         ST_INACK:
            if (ce & host_hs_valid)
            begin
               next_state = ST_IDLE;
               in_set     = 1'b1;
               irq_fire   = 1'b1;
               ack_set    = host_hs_ack;
               mode_we    = host_hs_ack;
            end
            // A new token means the host answer was lost
            else if (ce & tok_valid)
               next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // lock on any ACK moved on control endpoint
   wire lock_set = ack_set & (cur_ep == 2'h0);

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state    <= ST_IDLE;
         cur_ep   <= 2'h0;
         cur_pid  <= PID_SETUP;
         cur_resp <= RSP_IGNORE;
         rx_idx   <= 4'h0;
      end
      else if (ce)
      begin
         state <= next_state;
         if (tok_take)
         begin
            cur_ep   <= tok_ep;
            cur_pid  <= tok_pid;
            cur_resp <= tok_resp;
            rx_idx   <= 4'h0;
         end
         else if (state == ST_DATA && rx_valid && rx_idx < 4'(EP_SIZE))
            rx_idx <= rx_idx + 4'h1;
      end
   end

   // Control endpoint token flags, hardware set wins over CPU write
   wire wr_m0 = wr_go & wr_ok & (wr_ep == 2'h0) & (wr_reg == REG_MODE) & s_axi_wstrb[0] & ~lock0;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         setup_f <= 1'b0;
         in_f    <= 1'b0;
         out_f   <= 1'b0;
         lock0   <= 1'b0;
      end
      else if (ce)
      begin
         // SETUP flag at data phase start
         if (state == ST_DATA && cur_pid == PID_SETUP && cur_ep == 2'h0 && rx_start)
            setup_f <= 1'b1;
         else if (wr_m0)
            setup_f <= s_axi_wdata[F_SETUP];
         // IN and OUT flags at transaction end
         if (in_set && cur_ep == 2'h0)
            in_f <= 1'b1;
         else if (tok_take && tok_pid == PID_IN && tok_ep == 2'h0 && tok_resp != RSP_IGNORE && tok_resp != RSP_TXCNT
                  && tok_resp != RSP_TX0)
            in_f <= 1'b1;
         else if (wr_m0)
            in_f <= s_axi_wdata[F_IN];
         if (out_set && cur_ep == 2'h0)
            out_f <= 1'b1;
         else if (wr_m0)
            out_f <= s_axi_wdata[F_OUT];
         lock0 <= lock_set | (lock0 & ~unlock);
      end
   end

   // Per-endpoint mode, count and buffer storage
   for (genvar e = 0; e < NUM_EP; e++)
   begin : g_ep
      wire sel    = (cur_ep == 2'(e));
      wire wr_sel = wr_go & wr_ok & (wr_ep == 2'(e));
      // Lock covers only mode and count, not the data bytes
      wire wr_lk  = wr_sel & ~((e == 0) & lock0);
      wire wr_m   = wr_lk & (wr_reg == REG_MODE) & s_axi_wstrb[0];
      wire wr_c   = wr_lk & (wr_reg == REG_COUNT) & s_axi_wstrb[0];

      always_ff @(posedge clock or negedge rst_b)
      begin
         if (!rst_b)
         begin
            mode[e]  <= MODE_DISABLE;
            stall[e] <= 1'b0;
            ack_f[e] <= 1'b0;
            count[e] <= 4'h0;
            dval[e]  <= 1'b0;
            tog[e]   <= 1'b0;
         end
         else if (ce)
         begin
            if (mode_we && sel)
               mode[e] <= mode_val;
            else if (wr_m)
               mode[e] <= s_axi_wdata[3:0];
            if (wr_m)
               stall[e] <= (e != 0) & s_axi_wdata[F_STALL];
            if (ack_set && sel)
               ack_f[e] <= 1'b1;
            else if (wr_m)
               ack_f[e] <= s_axi_wdata[F_ACK];
            if (cnt_we && sel)
            begin
               count[e] <= rx_count[3:0];
               tog[e]   <= rx_toggle;
               dval[e]  <= dval_val;
            end
            else if (wr_c)
            begin
               count[e] <= s_axi_wdata[3:0];
               tog[e]   <= s_axi_wdata[F_TOG];
               dval[e]  <= s_axi_wdata[F_DVAL];
            end
         end
      end

      for (genvar b = 0; b < EP_SIZE; b++)
      begin : g_byte
         wire wr_b = wr_sel & (wr_reg == ((b < 4) ? REG_DATA_LO : REG_DATA_HI)) & s_axi_wstrb[b % 4];
         always_ff @(posedge clock or negedge rst_b)
         begin
            if (!rst_b)
               bufm[e][b] <= 8'h00;
            else if (rx_we && sel && rx_idx == 4'(b))
               bufm[e][b] <= rx_byte;
            else if (ce && wr_b)
               bufm[e][b] <= s_axi_wdata[8 * (b % 4) +: 8];
         end
      end
   end

   // Read data selection
   wire [1:0]  re = rd_ok ? rd_ep : 2'h0;
   wire [7:0]  rd_mode0 = {setup_f, in_f, out_f, ack_f[0], mode[0]};
   wire [7:0]  rd_mode  = (re == 2'h0) ? rd_mode0 : {stall[re], 2'h0, ack_f[re], mode[re]};
   wire [7:0]  rd_count = {tog[re], dval[re], 2'h0, count[re]};
   wire [31:0] rd_lo    = {bufm[re][3], bufm[re][2], bufm[re][1], bufm[re][0]};
   wire [31:0] rd_hi    = {bufm[re][7], bufm[re][6], bufm[re][5], bufm[re][4]};
   wire [31:0] rd_word  = !rd_ok                ? 32'h0000_0000 :
                          (rd_reg == REG_MODE)  ? {24'h00_0000, rd_mode} :
                          (rd_reg == REG_COUNT) ? {24'h00_0000, rd_count} :
                          (rd_reg == REG_DATA_LO) ? rd_lo : rd_hi;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= rd_word;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Link-side outputs
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hs_valid  <= 1'b0;
         hs_code   <= HS_NAK;
         tx_len    <= 4'h0;
         tx_toggle <= 1'b0;
         tx_byte   <= 8'h00;
         ep_irq    <= 3'h0;
      end
      else if (ce)
      begin
         hs_valid <= hs_fire;
         ep_irq   <= 3'h0;
         if (hs_fire)
            hs_code <= hs_sel;
         if (tok_take)
         begin
            tx_len    <= (tok_resp == RSP_TXCNT) ? count[tok_ep] : 4'h0;
            tx_toggle <= tog[tok_ep];
         end
         if (irq_fire)
            ep_irq[cur_ep] <= 1'b1;
         else if (tok_take && tok_pid == PID_IN && (tok_resp == RSP_NAK || tok_resp == RSP_STALL))
            ep_irq[tok_ep] <= 1'b1;
         tx_byte <= bufm[cur_ep][tx_index];
      end
   end

endmodule

// ==== shared/usbr_pkg.sv ====
package usbr_pkg;
   // Endpoint geometry
   localparam int         NUM_EP    = 3;
   localparam int         EP_SIZE   = 8;
   localparam logic [4:0] PKT_MAX   = 5'h0a;
   localparam logic [4:0] ZLP_COUNT = 5'h02;

   // Endpoint mode encodings
   localparam logic [3:0] MODE_DISABLE       = 4'h0;
   localparam logic [3:0] MODE_NAK_INOUT     = 4'h1;
   localparam logic [3:0] MODE_STATUS_OUT    = 4'h2;
   localparam logic [3:0] MODE_STALL_INOUT   = 4'h3;
   localparam logic [3:0] MODE_IGNORE_INOUT  = 4'h4;
   localparam logic [3:0] MODE_STATUS_IN     = 4'h6;
   localparam logic [3:0] MODE_NAK_OUT       = 4'h8;
   localparam logic [3:0] MODE_ACK_OUT       = 4'h9;
   localparam logic [3:0] MODE_NAKOUT_STATIN = 4'ha;
   localparam logic [3:0] MODE_ACKOUT_NAKIN  = 4'hb;
   localparam logic [3:0] MODE_NAK_IN        = 4'hc;
   localparam logic [3:0] MODE_ACK_IN        = 4'hd;
   localparam logic [3:0] MODE_NAKIN_STATOUT = 4'he;
   localparam logic [3:0] MODE_ACKIN_STATOUT = 4'hf;

   // Register map: byte address = ep * 0x10 + reg * 4
   localparam int         AEP_LSB     = 4;
   localparam int         AREG_LSB    = 2;
   localparam int         ATOP_LSB    = 6;
   localparam logic [1:0] REG_MODE    = 2'h0;
   localparam logic [1:0] REG_COUNT   = 2'h1;
   localparam logic [1:0] REG_DATA_LO = 2'h2;
   localparam logic [1:0] REG_DATA_HI = 2'h3;

   // Field positions
   localparam int F_ACK   = 4;
   localparam int F_OUT   = 5;
   localparam int F_IN    = 6;
   localparam int F_SETUP = 7;
   localparam int F_STALL = 7;
   localparam int F_DVAL  = 6;
   localparam int F_TOG   = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT} usbr_pid_t;
   typedef enum logic [2:0] {RSP_IGNORE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_TXCNT, RSP_TX0, RSP_CHECK} usbr_resp_t;
   typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} usbr_hs_t;
   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_INACK} usbr_state_t;
endpackage

// ==== tb/usbr_checker.sv ====
`timescale 1ns/1ps
module usbr_checker
   import usbr_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst_b,
   input wire logic       ce,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       tok_valid,
   input usbr_pid_t       tok_pid,
   input wire logic       tok_addr_ok,
   input wire logic       rx_done,
   input wire logic [4:0] rx_count,
   input wire logic       rx_ok,
   input wire logic       hs_valid,
   input usbr_hs_t        hs_code,
   input wire logic [2:0] ep_irq
);
   // Stalled clock enable freezes pulses, so it masks the checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b || !ce);
   a_hs_pulse: assert property (hs_valid |=> !hs_valid) else $error("handshake wider than one cycle");
   a_hs_cause:
      assert property (hs_valid |-> $past(rx_done) || $past(tok_valid && tok_pid == PID_IN)) else $error("stray answer");
   a_addr_miss: assert property (tok_valid && !tok_addr_ok |=> !hs_valid) else $error("foreign token answered");
   a_crc_bad: assert property (rx_done && !rx_ok |=> !hs_valid) else $error("bad packet answered");
   a_over_size: assert property (rx_done && rx_count > PKT_MAX |=> !hs_valid) else $error("long packet answered");
   a_hs_irq: assert property (hs_valid && hs_code != HS_DATA |-> ep_irq != 3'h0) else $error("no irq");
   a_irq_pulse: assert property (ep_irq != 3'h0 |=> ep_irq == 3'h0) else $error("irq wider than one cycle");
   a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write not answered");
endmodule
bind usbr_responder usbr_checker i_usbr_checker (.*);

// ==== tb/usbr_host_model.sv ====
`timescale 1ns/1ps
module usbr_host_model
   import usbr_pkg::*;
(
   input  wire logic  clock,
   output logic       tok_valid,
   output usbr_pid_t  tok_pid,
   output logic [1:0] tok_ep,
   output logic       tok_addr_ok,
   output logic       rx_start,
   output logic       rx_valid,
   output logic [7:0] rx_byte,
   output logic       rx_done,
   output logic [4:0] rx_count,
   output logic       rx_ok,
   output logic       rx_toggle,
   output logic       host_hs_valid,
   output logic       host_hs_ack
);
   initial
   begin
      {tok_valid, tok_ep, tok_addr_ok, rx_start, rx_valid, rx_byte, rx_done} = '0;
      {rx_count, rx_ok, rx_toggle, host_hs_valid, host_hs_ack} = '0;
      tok_pid = PID_SETUP;
   end
   // Token, then data phase only for SETUP and OUT
   task automatic run(input usbr_pid_t p, input logic [1:0] e, input logic [4:0] n, input logic ok, tg, ad);
      begin
         @(posedge clock);
         tok_valid   <= 1'h1;
         tok_pid     <= p;
         tok_ep      <= e;
         tok_addr_ok <= ad;
         @(posedge clock);
         tok_valid <= 1'h0;
         if (p != PID_IN)
         begin
            rx_start <= 1'h1;
            for (int i = 0; i + 2 < n; i++)
            begin
               @(posedge clock);
               rx_start <= 1'h0;
               rx_valid <= 1'h1;
               rx_byte  <= i[0] ? 8'ha5 : 8'h5a;
            end
            @(posedge clock);
            rx_start  <= 1'h0;
            rx_valid  <= 1'h0;
            rx_done   <= 1'h1;
            rx_count  <= n;
            rx_ok     <= ok;
            rx_toggle <= tg;
            @(posedge clock);
            rx_done <= 1'h0;
            // Idle byte lane must not look like held data
            rx_byte <= ~rx_byte;
         end
      end
   endtask
   task automatic answer(input logic a);
      begin
         @(posedge clock);
         host_hs_valid <= 1'h1;
         host_hs_ack   <= a;
         @(posedge clock);
         host_hs_valid <= 1'h0;
      end
   endtask
endmodule

// ==== tb/usbr_responder_tb_top.sv ====
`timescale 1ns/1ps
module usbr_responder_tb_top
   import usbr_pkg::*;
   ;
   logic        clock, rst_b, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tok_valid, tok_addr_ok;
   logic        rx_start, rx_valid, rx_done, rx_ok, rx_toggle, hs_valid, tx_toggle, host_hs_valid, host_hs_ack;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_byte, tx_byte;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0]  s_axi_wstrb, tx_len, hs_len;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tok_ep, rd_r;
   logic [4:0]  rx_count;
   logic [2:0]  tx_index, ep_irq;
   usbr_pid_t   tok_pid;
   usbr_hs_t    hs_code, hs_last;
   int          hs_n = 0;
   int          error_cnt, num_checks;
   usbr_responder  i_usbr_responder (.*);
   usbr_host_model i_usbr_host_model (.*);
   always #4 clock = ~clock;
   always @(posedge clock)
   begin
      if (hs_valid === 1'h1)
      begin
         hs_n    <= hs_n + 1;
         hs_last <= hs_code;
         hs_len  <= tx_len;
      end
   end
   task automatic chk(input logic ok, input string m);
      begin
         num_checks++;
         if (ok !== 1'h1)
         begin
            error_cnt++;
            $display("MISMATCH at %0t: %s", $time, m);
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clock);
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid  <= 1'h1;
         s_axi_bready  <= 1'h1;
         do @(negedge clock); while (s_axi_awready !== 1'h1 || s_axi_wready !== 1'h1);
         @(posedge clock);
         s_axi_awvalid <= 1'h0;
         s_axi_wvalid  <= 1'h0;
         do @(negedge clock); while (s_axi_bvalid !== 1'h1);
         chk(s_axi_bresp === RESP_OKAY, "write response");
         @(posedge clock);
         s_axi_bready <= 1'h0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      begin
         @(posedge clock);
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready  <= 1'h1;
         do @(negedge clock); while (s_axi_arready !== 1'h1);
         @(posedge clock);
         s_axi_arvalid <= 1'h0;
         do @(negedge clock); while (s_axi_rvalid !== 1'h1);
         rd_d = s_axi_rdata;
         rd_r = s_axi_rresp;
         @(posedge clock);
         s_axi_rready <= 1'h0;
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
      begin
         rd(a);
         chk((rd_d & m) === e && rd_r === RESP_OKAY, "register value");
      end
   endtask
   task automatic xfer(input usbr_pid_t p, input logic [1:0] e, input logic [4:0] n, input logic ok, tg, ad, an,
                       input usbr_hs_t c);
      int n0;
      begin
         n0 = hs_n;
         i_usbr_host_model.run(p, e, n, ok, tg, ad);
         repeat (3) @(posedge clock);
         chk((hs_n != n0) === an && (an === 1'h0 || hs_last === c), "handshake");
      end
   endtask
   task automatic t_control;
      begin
         rchk(8'h00, 32'h0000_000f, 32'h0000_0000);
         rd(8'h30);
         chk(rd_r === RESP_SLVERR, "unmapped read");
         xfer(PID_SETUP, 2'h0, 5'h0a, 1'h1, 1'h0, 1'h1, 1'h0, HS_ACK);
         wr(8'h00, 32'h0000_0001);
         xfer(PID_SETUP, 2'h0, 5'h0a, 1'h1, 1'h0, 1'h1, 1'h1, HS_ACK);
         rchk(8'h00, 32'h0000_00ff, 32'h0000_0091);
         xfer(PID_IN, 2'h0, 5'h00, 1'h1, 1'h0, 1'h1, 1'h1, HS_NAK);
         xfer(PID_OUT, 2'h0, 5'h02, 1'h1, 1'h1, 1'h1, 1'h1, HS_NAK);
         xfer(PID_SETUP, 2'h0, 5'h0a, 1'h1, 1'h0, 1'h1, 1'h1, HS_ACK);
         wr(8'h00, 32'h0000_000f);
         rchk(8'h00, 32'h0000_000f, 32'h0000_0001);
         wr(8'h00, 32'h0000_000f);
         xfer(PID_OUT, 2'h0, 5'h02, 1'h1, 1'h1, 1'h1, 1'h1, HS_ACK);
         rchk(8'h00, 32'h0000_000f, 32'h0000_000e);
         wr(8'h00, 32'h0000_000f);
         xfer(PID_OUT, 2'h0, 5'h04, 1'h1, 1'h1, 1'h1, 1'h1, HS_STALL);
         wr(8'h04, 32'h0000_0083);
         xfer(PID_IN, 2'h0, 5'h00, 1'h1, 1'h0, 1'h1, 1'h1, HS_DATA);
         chk(hs_len === 4'h3 && tx_toggle === 1'h1, "sent count");
         i_usbr_host_model.answer(1'h1);
         rchk(8'h00, 32'h0000_000f, 32'h0000_000e);
         wr(8'h00, 32'h0000_0006);
         xfer(PID_IN, 2'h0, 5'h00, 1'h1, 1'h0, 1'h1, 1'h1, HS_DATA);
         chk(hs_len === 4'h0, "empty packet");
         // Close the pending IN so the next token is taken
         i_usbr_host_model.answer(1'h0);
         $display("control endpoint test done");
      end
   endtask
   task automatic t_drop;
      begin
         wr(8'h00, 32'h0000_0001);
         xfer(PID_OUT, 2'h0, 5'h02, 1'h0, 1'h1, 1'h1, 1'h0, HS_NAK);
         xfer(PID_OUT, 2'h0, 5'h0b, 1'h1, 1'h1, 1'h1, 1'h0, HS_NAK);
         xfer(PID_IN, 2'h0, 5'h00, 1'h1, 1'h0, 1'h0, 1'h0, HS_NAK);
         wr(8'h00, 32'h0000_0004);
         xfer(PID_IN, 2'h0, 5'h00, 1'h1, 1'h0, 1'h1, 1'h0, HS_NAK);
         // Data endpoint keeps a non-SETUP mode
         wr(8'h10, 32'h0000_0009);
         xfer(PID_IN, 2'h1, 5'h00, 1'h1, 1'h0, 1'h1, 1'h0, HS_NAK);
         xfer(PID_OUT, 2'h1, 5'h04, 1'h1, 1'h0, 1'h1, 1'h1, HS_ACK);
         rchk(8'h10, 32'h0000_000f, 32'h0000_0008);
         rchk(8'h18, 32'h0000_ffff, 32'h0000_a55a);
         chk(tx_byte === 8'h5a, "buffer byte");
         wr(8'h10, 32'h0000_0089);
         xfer(PID_OUT, 2'h1, 5'h04, 1'h1, 1'h1, 1'h1, 1'h1, HS_STALL);
         $display("drop and data endpoint test done");
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      {clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_index, error_cnt, num_checks} = '0;
      ce = 1'h1;
      s_axi_wstrb = 4'hf;
      repeat (16) @(posedge clock);
      rst_b <= 1'h1;
      t_control;
      t_drop;
      close_out;
   end
   initial
   begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      close_out;
   end
endmodule
